// >>> rtl/data_file.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// General purpose RAM, four banks of 128 bytes
// ----------------------------------------------------------------
module data_file (
  // Clock
  input wire logic clk_i,
  // Access port
  input wire logic we_i,
  input wire logic [1:0] bank_i,
  input wire logic [6:0] ofs_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] ram [0:511];
  wire logic [8:0] idx;

  assign idx = {bank_i, ofs_i};

  // Combinational read so a bus read answers in the ack cycle
  assign rdata_o = ram[idx];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      ram[idx] <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/memmap_cfg.svh
`ifndef MEMMAP_CFG_SVH
`define MEMMAP_CFG_SVH
// Wishbone word indices (byte address = 4 * index)
`define WB_IDX_DATA_ADDR 4'h0
`define WB_IDX_DATA_WR 4'h1
`define WB_IDX_DATA_RD 4'h2
`define WB_IDX_FETCH_CTRL 4'h3
`define WB_IDX_PC 4'h4
`define WB_IDX_FETCH_ADDR 4'h5
`define WB_IDX_PROG_ADDR 4'h6
`define WB_IDX_PROG_DATA 4'h7
// Data file offsets within a bank
`define OFS_INDIRECT 7'h00
`define OFS_PCL 7'h02
`define OFS_STATUS 7'h03
`define OFS_FSR 7'h04
`define OFS_PROGRAM_COUNTER_LATCH_HIGH 7'h0a
`define OFS_GPR_FIRST 7'h20
// Status field positions
`define STATUS_BANK_HI 6
`define STATUS_BANK_LO 5
// Vectors and reset values
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004
`define STATUS_RESET 8'h18
`define FSR_RESET 8'h00
`define PROGRAM_COUNTER_LATCH_HIGH_RESET 8'h00
// Fetch control bits
`define FC_STEP 0
`define FC_IRQ 1
`define FC_SMALL 2
`endif

// >>> rtl/memmap_pkg.sv
`default_nettype none
package memmap_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK = 3'b010,
    ST_HOLD = 3'b100
  } wb_state_t;
  typedef logic [12:0] prog_addr_t;
  typedef logic [13:0] prog_word_t;
  typedef logic [8:0] data_addr_t;
endpackage
`default_nettype wire

// >>> rtl/memmap_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "memmap_cfg.svh"
// How it works
// [RQ1] Thirteen-bit program counter addresses 8K words of 14 bits.
// [RQ2] Small variant has 4K words; higher fetch addresses wrap around.
// [RQ3] Reset loads the program counter with zero.
// [RQ4] Taking an interrupt jumps to word address 0004h.
// [RQ5] Status bits 6 and 5 select one of four data banks.
// [RQ6] Each bank spans offsets 00h to 7Fh, 128 bytes.
// [RQ7] Low offsets decode to special registers, higher ones to RAM.
// [RQ8] Core registers are mirrored at the same offset in every bank.
// [RQ9] Data file reachable directly or indirectly through the pointer.
// [RQ10] Program and data stores use separate buses, concurrent access.
// [RQ11] Offset zero has no storage; it redirects through the pointer.
// [RQ12] Direct address is bank bits above the seven-bit offset.
module memmap_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Fetch state
  output logic [12:0] pc_o,
  output logic [13:0] instr_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  memmap_pkg::wb_state_t state_q, state_d;
  memmap_pkg::prog_addr_t pc_q;
  logic [7:0] status_q;
  logic [7:0] fsr_q;
  logic [7:0] program_counter_latch_high_q;
  logic [8:0] daddr_q;
  logic [12:0] paddr_q;
  logic small_q;
  logic [31:0] dat_q;
  logic ack_q;
  logic [13:0] instr_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic req;
  wire logic [3:0] idx;
  wire logic in_map;
  wire logic wr_go;
  wire logic rd_go;
  wire logic lane0;
  assign req = cyc_i && stb_i && (state_q == memmap_pkg::ST_IDLE);
  assign idx = adr_i[5:2];
  assign in_map = (adr_i[31:6] == 26'h0) && (adr_i[1:0] == 2'h0);
  assign lane0 = sel_i[0];
  assign wr_go = req && we_i && in_map;
  assign rd_go = req && !we_i;

  // Register index hit; unmapped words read zero and ignore writes
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  wire logic hit_daddr;
  wire logic hit_dwr;
  wire logic hit_drd;
  wire logic hit_fctl;
  wire logic hit_pc;
  wire logic hit_faddr;
  wire logic hit_paddr;
  wire logic hit_pdata;
  assign hit_daddr = in_map && hit(idx, `WB_IDX_DATA_ADDR);
  assign hit_dwr = in_map && hit(idx, `WB_IDX_DATA_WR);
  assign hit_drd = in_map && hit(idx, `WB_IDX_DATA_RD);
  assign hit_fctl = in_map && hit(idx, `WB_IDX_FETCH_CTRL);
  assign hit_pc = in_map && hit(idx, `WB_IDX_PC);
  assign hit_faddr = in_map && hit(idx, `WB_IDX_FETCH_ADDR);
  assign hit_paddr = in_map && hit(idx, `WB_IDX_PROG_ADDR);
  assign hit_pdata = in_map && hit(idx, `WB_IDX_PROG_DATA);

  // ----------------------------------------------------------------
  // Data file address formation
  // ----------------------------------------------------------------
  wire logic [1:0] bank_sel;
  wire logic [6:0] ofs_raw;
  wire logic indirect;
  wire logic [8:0] eff_addr;
  wire logic [6:0] eff_ofs;
  wire logic [1:0] eff_bank;
  // Bank bits straight from status
  assign bank_sel = {status_q[`STATUS_BANK_HI],
                     status_q[`STATUS_BANK_LO]}; // [RQ5]
  assign ofs_raw = daddr_q[6:0]; // [RQ6]
  // Offset zero carries no storage and goes through the pointer
  assign indirect = (ofs_raw == `OFS_INDIRECT); // [RQ11]
  // Pointer supplies low eight bits, bank high bit from status
  assign eff_addr = indirect ? {status_q[`STATUS_BANK_HI], fsr_q} // [RQ9]
                             : {bank_sel, ofs_raw}; // [RQ12]
  assign eff_ofs = eff_addr[6:0];
  assign eff_bank = eff_addr[8:7];

  // Mirrored core registers answer in all banks
  wire logic sel_pcl;
  wire logic sel_stat;
  wire logic sel_fsr;
  wire logic sel_plath;
  wire logic sel_gpr;
  wire logic sel_ind;
  assign sel_pcl = (eff_ofs == `OFS_PCL); // [RQ8]
  assign sel_stat = (eff_ofs == `OFS_STATUS);
  assign sel_fsr = (eff_ofs == `OFS_FSR);
  assign sel_plath = (eff_ofs == `OFS_PROGRAM_COUNTER_LATCH_HIGH);
  assign sel_ind = (eff_ofs == `OFS_INDIRECT);
  assign sel_gpr = (eff_ofs >= `OFS_GPR_FIRST); // [RQ7]

  wire logic [7:0] ram_rdata;
  wire logic ram_we;
  assign ram_we = wr_go && hit_dwr && lane0 && sel_gpr;

  data_file i_data_file (
    .clk_i(clk_i),
    .we_i(ram_we),
    .bank_i(eff_bank),
    .ofs_i(eff_ofs),
    .wdata_i(dat_i[7:0]),
    .rdata_o(ram_rdata)
  );

  // Unimplemented special registers and indirect-through-itself read 0
  wire logic [7:0] file_rdata;
  assign file_rdata = sel_pcl ? pc_q[7:0] :
                      sel_stat ? status_q :
                      sel_fsr ? fsr_q :
                      sel_plath ? program_counter_latch_high_q :
                      (sel_gpr && !sel_ind) ? ram_rdata : 8'h00;

  wire logic file_wr;
  assign file_wr = wr_go && hit_dwr && lane0;

  // ----------------------------------------------------------------
  // Program counter and fetch
  // ----------------------------------------------------------------
  wire logic step_go;
  wire logic irq_go;
  wire logic pc_wr;
  wire logic pcl_wr;
  wire memmap_pkg::prog_addr_t pc_d;
  assign step_go = wr_go && hit_fctl && lane0 && dat_i[`FC_STEP];
  assign irq_go = wr_go && hit_fctl && lane0 && dat_i[`FC_IRQ];
  assign pc_wr = wr_go && hit_pc && lane0 && sel_i[1];
  assign pcl_wr = file_wr && sel_pcl;
  // Interrupt beats step; a low-byte write pulls high bits from latch
  assign pc_d = irq_go ? `IRQ_VECTOR : // [RQ4]
                pc_wr ? dat_i[12:0] :
                pcl_wr ? {program_counter_latch_high_q[4:0], dat_i[7:0]} :
                step_go ? 13'(pc_q + 13'h1) : pc_q; // [RQ1]

  wire memmap_pkg::prog_word_t fetch_word;
  wire memmap_pkg::prog_word_t load_rdata;
  wire logic prog_we;
  assign prog_we = wr_go && hit_pdata && lane0;

  prog_store i_prog_store (
    .clk_i(clk_i),
    .small_i(small_q),
    .fetch_addr_i(pc_q),
    .fetch_data_o(fetch_word),
    .load_we_i(prog_we),
    .load_addr_i(paddr_q),
    .load_data_i(dat_i[13:0]),
    .load_rdata_o(load_rdata)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (!in_map) begin
      rd_mux = 32'h0;
    end else if (hit_daddr) begin
      rd_mux = {23'h0, daddr_q};
    end else if (hit_drd || hit_dwr) begin
      rd_mux = {24'h0, file_rdata};
    end else if (hit_fctl) begin
      rd_mux = {29'h0, small_q, 2'h0};
    end else if (hit_pc) begin
      rd_mux = {19'h0, pc_q};
    end else if (hit_faddr) begin
      rd_mux = {23'h0, eff_addr};
    end else if (hit_paddr) begin
      rd_mux = {19'h0, paddr_q};
    end else if (hit_pdata) begin
      rd_mux = {18'h0, load_rdata};
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake: ack one cycle after take, then one idle cycle
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      memmap_pkg::ST_IDLE: begin
        if (cyc_i && stb_i) begin
          state_d = memmap_pkg::ST_ACK;
        end
      end
      memmap_pkg::ST_ACK: state_d = memmap_pkg::ST_HOLD;
      memmap_pkg::ST_HOLD: state_d = memmap_pkg::ST_IDLE;
      default: state_d = memmap_pkg::ST_IDLE;
    endcase
  end

  // Writes commit at take; read data captured then, held stable
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= memmap_pkg::ST_IDLE;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      state_q <= state_d;
      ack_q <= req;
      if (rd_go) begin
        dat_q <= rd_mux;
      end
    end
  end

  // Core registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_q <= `RESET_VECTOR; // [RQ3]
      status_q <= `STATUS_RESET;
      fsr_q <= `FSR_RESET;
      program_counter_latch_high_q <= `PROGRAM_COUNTER_LATCH_HIGH_RESET;
      daddr_q <= 9'h0;
      paddr_q <= 13'h0;
      small_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      if (file_wr && sel_stat) begin
        status_q <= dat_i[7:0];
      end
      if (file_wr && sel_fsr) begin
        fsr_q <= dat_i[7:0];
      end
      if (file_wr && sel_plath) begin
        program_counter_latch_high_q <= dat_i[7:0];
      end
      if (wr_go && hit_daddr && lane0) begin
        daddr_q <= {sel_i[1] ? dat_i[8] : daddr_q[8], dat_i[7:0]};
      end
      if (wr_go && hit_paddr && lane0) begin
        paddr_q <= dat_i[12:0];
      end
      if (wr_go && hit_fctl && lane0) begin
        small_q <= dat_i[`FC_SMALL];
      end
    end
  end

  // Fetch word registered once more for a clean output
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      instr_q <= 14'h0;
    end else begin
      instr_q <= fetch_word; // [RQ10]
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign pc_o = pc_q;
  assign instr_o = instr_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_pc_a: assert property (@(posedge clk_i) // [RQ3]
    $rose(rstn_i) |-> pc_q == 13'h0 || $past(irq_go) || $past(pc_wr))
    else $error("pc not zero after reset");
  irq_vec_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ4]
    irq_go |=> pc_q == 13'h0004)
    else $error("interrupt did not load vector");
  step_inc_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ1]
    step_go && !irq_go && !pc_wr && !pcl_wr |=> pc_q == $past(pc_q) + 13'h1)
    else $error("pc step wrong");
  bank_form_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ12]
    !indirect |-> eff_addr == {status_q[6:5], daddr_q[6:0]})
    else $error("direct address wrong");
  ind_form_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ11]
    indirect |-> eff_addr[7:0] == fsr_q)
    else $error("indirect address wrong");
  mirror_pcl_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ8]
    rd_go && hit_drd && sel_pcl |=> dat_q[7:0] == $past(pc_q[7:0]))
    else $error("pcl mirror read wrong");
  gpr_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ7]
    ram_we |=> ram_rdata == $past(dat_i[7:0]))
    else $error("ram write not stored");
  ack_once_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ack_q |=> !ack_q)
    else $error("ack held two cycles");
  stat_wr_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RQ5]
    file_wr && sel_stat |=> status_q == $past(dat_i[7:0]))
    else $error("status write lost");
  c_irq: cover property (@(posedge clk_i) disable iff (!rstn_i) irq_go);
  c_ind: cover property (@(posedge clk_i) disable iff (!rstn_i)
    file_wr && indirect && sel_gpr);
  c_bank3: cover property (@(posedge clk_i) disable iff (!rstn_i)
    ram_we && eff_bank == 2'h3);
endmodule
`default_nettype wire

// >>> rtl/prog_store.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Program store, 8K x 14, with wraparound for the small variant
// ----------------------------------------------------------------
module prog_store (
  // Clock
  input wire logic clk_i,
  // Variant select
  input wire logic small_i,
  // Fetch port
  input wire memmap_pkg::prog_addr_t fetch_addr_i,
  output memmap_pkg::prog_word_t fetch_data_o,
  // Load port
  input wire logic load_we_i,
  input wire memmap_pkg::prog_addr_t load_addr_i,
  input wire memmap_pkg::prog_word_t load_data_i,
  output memmap_pkg::prog_word_t load_rdata_o
);
  memmap_pkg::prog_word_t mem [0:8191];
  wire memmap_pkg::prog_addr_t fetch_wrap;
  wire memmap_pkg::prog_addr_t load_wrap;

  // Small part drops the top address bit, so high fetches fold down
  assign fetch_wrap = small_i ? {1'b0, fetch_addr_i[11:0]} : fetch_addr_i; // [RQ2]
  assign load_wrap = small_i ? {1'b0, load_addr_i[11:0]} : load_addr_i;

  // Own port for fetch, apart from the data file bus
  always_ff @(posedge clk_i) begin // [RQ10]
    if (load_we_i) begin
      mem[load_wrap] <= load_data_i;
    end
    fetch_data_o <= mem[fetch_wrap];
    load_rdata_o <= mem[load_wrap];
  end
endmodule
`default_nettype wire

// >>> testbench/test_banked_memory_address_map.sv
`timescale 1ns/10ps
`default_nettype none
`include "memmap_cfg.svh"
module test_banked_memory_address_map;
  // ----------------------------------------
  // Bench signals and reference model state
  // ----------------------------------------
  logic clk_i, rstn_i, cyc_i, stb_i, we_i, ack_o;
  logic [3:0] sel_i;
  logic [31:0] adr_i, dat_i, dat_o, rd;
  logic [12:0] pc_o;
  logic [13:0] instr_o;
  int errors, total_checks, seed, ofs, a, v, pc_m, small_m, fsr_m;
  int ram[512];
  int prog[8192];
  int tbl[6] = '{0, 4, 8191, 4095, 291, 4387};
  int ofl[3] = '{32, 127, 80};

  memmap_top i_memmap_top (.clk_i(clk_i), .rstn_i(rstn_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pc_o(pc_o),
    .instr_o(instr_o));

  // Free running 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  // Classic cycle: hold everything until ack is seen, then release
  task automatic wb(input logic w, input logic [3:0] idx,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= s;
    adr_i <= {26'h0, idx, 2'b00};
    dat_i <= d;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // Data file access goes through the address register first
  task automatic dwr(input int o, input int d);
    wb(1'b1, `WB_IDX_DATA_ADDR, 32'(o), 4'h3);
    wb(1'b1, `WB_IDX_DATA_WR, 32'(d), 4'h1);
  endtask

  task automatic drd(input int o);
    wb(1'b1, `WB_IDX_DATA_ADDR, 32'(o), 4'h3);
    wb(1'b0, `WB_IDX_DATA_RD, 32'h0, 4'hf);
  endtask

  task automatic chk_rd(input logic [31:0] exp);
    total_checks++;
    if (rd !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: read %h want %h", $time, rd, exp);
    end
  endtask

  // Fetch word trails pc by two cycles, so let three edges pass
  task automatic chk_fetch(input bit with_instr);
    logic [13:0] w;
    repeat (3) @(posedge clk_i);
    #1;
    w = 14'(prog[small_m ? (pc_m & 4095) : pc_m]);
    total_checks++;
    if (pc_o !== 13'(pc_m) || (with_instr && instr_o !== w)) begin
      errors++;
      $display("CHECK FAILED at %0t: pc %h instr %h", $time, pc_o, instr_o);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the several hundred cycles the run needs
  initial begin
    #(40 * 40000);
    errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 59807;
    small_m = 0;
    pc_m = 0;
    {rstn_i, cyc_i, stb_i, we_i} = 4'h0;
    sel_i = 4'h0;
    adr_i = 32'h0;
    dat_i = 32'h0;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk_fetch(1'b0);
    drd(`OFS_STATUS);
    chk_rd(32'h18);
    drd(`OFS_FSR);
    chk_rd(32'h0);
    // Load program words, including the top word and the vectors
    foreach (tbl[k]) begin
      prog[tbl[k]] = $random(seed) & 16'h3fff;
      wb(1'b1, `WB_IDX_PROG_ADDR, 32'(tbl[k]), 4'h3);
      wb(1'b1, `WB_IDX_PROG_DATA, 32'(prog[tbl[k]]), 4'h3);
      wb(1'b0, `WB_IDX_PROG_DATA, 32'h0, 4'hf);
      chk_rd(32'(prog[tbl[k]]));
    end
    // Fetch runs while the data bus is busy with another access
    foreach (tbl[k]) begin
      pc_m = tbl[k];
      wb(1'b1, `WB_IDX_PC, 32'(pc_m), 4'h3);
      drd(`OFS_FSR);
      chk_fetch(1'b1);
    end
    // Step from the top word wraps to zero, then the vector
    pc_m = 8191;
    wb(1'b1, `WB_IDX_PC, 32'(pc_m), 4'h3);
    wb(1'b1, `WB_IDX_FETCH_CTRL, 32'h1, 4'h1);
    pc_m = 0;
    chk_fetch(1'b1);
    wb(1'b1, `WB_IDX_FETCH_CTRL, 32'h3, 4'h1);
    pc_m = 4;
    chk_fetch(1'b1);
    wb(1'b0, `WB_IDX_PC, 32'h0, 4'hf);
    chk_rd(32'h4);
    // Small variant folds the upper half onto the lower
    wb(1'b1, `WB_IDX_FETCH_CTRL, 32'h4, 4'h1);
    wb(1'b0, `WB_IDX_FETCH_CTRL, 32'h0, 4'hf);
    chk_rd(32'h4);
    small_m = 1;
    pc_m = 4387;
    wb(1'b1, `WB_IDX_PC, 32'(pc_m), 4'h3);
    chk_fetch(1'b1);
    wb(1'b1, `WB_IDX_FETCH_CTRL, 32'h0, 4'h1);
    small_m = 0;
    chk_fetch(1'b1);
    // Same offsets in all four banks hold separate bytes
    fsr_m = $random(seed) & 8'hff;
    dwr(`OFS_FSR, fsr_m);
    for (int b = 0; b < 4; b++) begin
      dwr(`OFS_STATUS, b << 5);
      foreach (ofl[j]) begin
        ram[b * 128 + ofl[j]] = $random(seed) & 8'hff;
        dwr(ofl[j], ram[b * 128 + ofl[j]]);
      end
    end
    for (int b = 0; b < 4; b++) begin
      dwr(`OFS_STATUS, b << 5);
      drd(`OFS_STATUS);
      rd = rd & 32'h60;
      chk_rd(32'(b << 5));
      foreach (ofl[j]) begin
        drd(ofl[j]);
        chk_rd(32'(ram[b * 128 + ofl[j]]));
        wb(1'b0, `WB_IDX_FETCH_ADDR, 32'h0, 4'hf);
        chk_rd(32'(b * 128 + ofl[j]));
      end
      drd(`OFS_FSR);
      chk_rd(32'(fsr_m));
      drd(1);
      chk_rd(32'h0);
    end
    // Indirect access through the pointer, checked again directly
    for (int k = 0; k < 4; k++) begin
      fsr_m = (k & 1) * 128 + 32 + ($unsigned($random(seed)) % 96);
      a = (k >> 1) * 256 + fsr_m;
      v = $random(seed) & 8'hff;
      ram[a] = v;
      dwr(`OFS_STATUS, k << 5);
      dwr(`OFS_FSR, fsr_m);
      dwr(`OFS_INDIRECT, v);
      drd(`OFS_INDIRECT);
      chk_rd(32'(v));
      dwr(`OFS_STATUS, (a >> 7) << 5);
      drd(a & 127);
      chk_rd(32'(v));
    end
    // Low pc byte written through the data file takes the latch
    dwr(`OFS_PROGRAM_COUNTER_LATCH_HIGH, 8'hff);
    dwr(`OFS_PCL, 8'hff);
    pc_m = 8191;
    chk_fetch(1'b1);
    drd(`OFS_PCL);
    chk_rd(32'hff);
    // Mid-run reset must pull a nonzero pc back to the reset vector
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    pc_m = 0;
    chk_fetch(1'b1);
    drd(`OFS_STATUS);
    chk_rd(32'h18);
    // Write without lane 0 is dropped; unmapped index reads zero
    dwr(`OFS_STATUS, 0);
    wb(1'b1, `WB_IDX_DATA_ADDR, 32'h20, 4'h3);
    wb(1'b1, `WB_IDX_DATA_WR, 32'(ram[32] ^ 255), 4'h2);
    wb(1'b0, `WB_IDX_DATA_RD, 32'h0, 4'hf);
    chk_rd(32'(ram[32]));
    wb(1'b0, 4'hc, 32'h0, 4'hf);
    chk_rd(32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
